// *** verilog/bil_regs.svh ***
`ifndef BIL_REGS_SVH
`define BIL_REGS_SVH

// Physical acknowledge locations, one per captured timer interrupt.
`define BIL_ACK_A_ADDR      32'h1f80_0010
`define BIL_ACK_B_ADDR      32'h1f80_0014

// Physical window of the bus: kernel aliases fold onto it by dropping the top three bits.
`define BIL_PHYS_MASK       32'h1fff_ffff

// Bit positions inside the three-bit processor interrupt group Int(5:3).
`define BIL_INT_TIMER_A     0
`define BIL_INT_TIMER_B     1
`define BIL_INT_UART        2
`define BIL_INT_WIDTH       3

// Reset values: no capture pending, every active-low interrupt negated.
`define BIL_CAPTURE_RST     2'h0
`define BIL_INT_N_RST       3'h7

// Synchroniser depth for inputs that arrive from other chips.
`define BIL_SYNC_STAGES     3

`endif

// *** verilog/bil_pkg.sv ***
`default_nettype none

package bil_pkg;

	// Interrupt sources as seen at the pins of this block.
	typedef struct packed {
		logic uart_irq_out_n;
		logic timer_b_output;
		logic timer_a_output;
	} bil_src_t;

	// Processor bus view needed to spot an acknowledge read.
	typedef struct packed {
		logic [31:0] addr;
		logic        rd_n;
	} bil_bus_t;

	// Acknowledge events, one-cycle pulses.
	typedef struct packed {
		logic ack_b;
		logic ack_a;
	} bil_ack_t;

	// Read-strobe tracker, Gray coded along idle to read and back.
	typedef enum logic [1:0] {
		BIL_BUS_IDLE = 2'b00,
		BIL_BUS_READ = 2'b01
	} bil_bus_state_t;

endpackage

`default_nettype wire

// *** verilog/bil_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser with agreement filter and edge pulses.
module bil_pin_sync (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Raw pin and its reset level.
	input  wire logic pin_in,
	input  wire logic rst_level,
	// Filtered level and edge pulses.
	output logic      level_q,
	output logic      rise,
	output logic      fall
);

	logic meta_q;
	logic s2_q;
	logic s3_q;
	logic stable_q;
	logic prev_q;

	// The first stage is read only by the second, so metastability cannot leak into logic.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			s2_q   <= 1'b0;
			s3_q   <= 1'b0;
		end else begin
			meta_q <= pin_in;
			s2_q   <= meta_q;
			s3_q   <= s2_q;
		end
	end

	// A change counts only once the second and third stages agree.
	// The filtered level starts low after reset, so a line already high at release reads as a rising edge.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stable_q <= 1'b0;
			prev_q   <= 1'b0;
		end else if (s2_q == s3_q) begin
			stable_q <= s3_q;
			prev_q   <= stable_q;
		end else begin
			prev_q   <= stable_q;
		end
	end

	assign level_q = stable_q;
	assign rise    = stable_q & ~prev_q;
	assign fall    = ~stable_q & prev_q;

	// Every caller ties the reset level low, matching the zero the stages reset to, so it is not used.
	logic unused_rst_level;
	assign unused_rst_level = rst_level;

endmodule

`default_nettype wire

// *** verilog/bil_irq_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bil_regs.svh"

module bil_irq_latch (
	// Clock (bus clock) and board reset.
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Peripheral interrupt pins.
	input  wire bil_pkg::bil_src_t src,
	// Processor bus, synchronous to the bus clock.
	input  wire bil_pkg::bil_bus_t bus,
	// Processor interrupt inputs Int(5:3), active low.
	output logic [`BIL_INT_WIDTH-1:0] cpu_int_n,
	// Acknowledge observation pulses.
	output bil_pkg::bil_ack_t         ack,
	// Pending timer captures, bit 0 timer A, bit 1 timer B.
	output logic [1:0]                timer_pending
);

	// Returns true when a bus address, after folding kernel aliases, names the target.
	function automatic logic ack_match(input logic [31:0] addr, input logic [31:0] target);
		ack_match = ((addr & `BIL_PHYS_MASK) == target);
	endfunction

	// Synchronised pin levels and edges.
	logic ta_level;
	logic ta_rise;
	logic tb_level;
	logic tb_rise;
	logic uart_level_n;

	// Timer lines are active high; their rising edge is the asserting transition.
	bil_pin_sync u_sync_ta (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.pin_in    (src.timer_a_output),
		.rst_level (1'b0),
		.level_q   (ta_level),
		.rise      (ta_rise),
		.fall      ()
	);

	bil_pin_sync u_sync_tb (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.pin_in    (src.timer_b_output),
		.rst_level (1'b0),
		.level_q   (tb_level),
		.rise      (tb_rise),
		.fall      ()
	);

	// The UART line is open collector and active low; it is only synchronised, never held.
	// Its filtered level starts at zero, so it is inverted twice to keep reset negated.
	logic uart_active;
	bil_pin_sync u_sync_uart (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.pin_in    (~src.uart_irq_out_n),
		.rst_level (1'b0),
		.level_q   (uart_active),
		.rise      (),
		.fall      ()
	);
	assign uart_level_n = ~uart_active;

	// Read-strobe tracker so that a long read clears its capture once, at its start.
	bil_pkg::bil_bus_state_t bus_state_q;
	bil_pkg::bil_bus_state_t bus_state_d;
	logic                    rd_start;

	always_comb begin
		bus_state_d = bus_state_q;
		rd_start    = 1'b0;
		unique case (bus_state_q)
			bil_pkg::BIL_BUS_IDLE: begin
				if (!bus.rd_n) begin
					bus_state_d = bil_pkg::BIL_BUS_READ;
					rd_start    = 1'b1;
				end
			end
			bil_pkg::BIL_BUS_READ: begin
				if (bus.rd_n) begin
					bus_state_d = bil_pkg::BIL_BUS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bus_state_q <= bil_pkg::BIL_BUS_IDLE;
		end else begin
			bus_state_q <= bus_state_d;
		end
	end

	// Acknowledge decode; the data byte is left to the timer chip, this block drives no data.
	logic clr_a;
	logic clr_b;
	assign clr_a = rd_start & ack_match(bus.addr, `BIL_ACK_A_ADDR);
	assign clr_b = rd_start & ack_match(bus.addr, `BIL_ACK_B_ADDR);

	// Capture flags. A new edge in the clearing cycle wins, so no timer event is lost.
	logic [1:0] capture_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			capture_q <= `BIL_CAPTURE_RST;
		end else begin
			if (ta_rise) begin
				capture_q[0] <= 1'b1;
			end else if (clr_a) begin
				capture_q[0] <= 1'b0;
			end
			if (tb_rise) begin
				capture_q[1] <= 1'b1;
			end else if (clr_b) begin
				capture_q[1] <= 1'b0;
			end
		end
	end

	// Processor interrupt pins come from flip-flops to avoid decode glitches on Int(5:3).
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cpu_int_n <= `BIL_INT_N_RST;
		end else begin
			cpu_int_n[`BIL_INT_UART]    <= uart_level_n;
			cpu_int_n[`BIL_INT_TIMER_B] <= ~capture_q[1];
			cpu_int_n[`BIL_INT_TIMER_A] <= ~capture_q[0];
		end
	end

	// Acknowledge pulses and pending status, registered for clean observation.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack           <= '0;
			timer_pending <= `BIL_CAPTURE_RST;
		end else begin
			ack.ack_a     <= clr_a;
			ack.ack_b     <= clr_b;
			timer_pending <= capture_q;
		end
	end

	// Filtered timer levels are kept only for edge detection; captures ignore them.
	logic unused_levels;
	assign unused_levels = ta_level ^ tb_level;

endmodule

`default_nettype wire

// *** test/bil_irq_latch_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bil_regs.svh"

// Port watcher; a timer edge that meets its own clear keeps the capture, so that case is excluded from the clear check.
module bil_irq_latch_properties (
	input wire logic              clk_sys,
	input wire logic              resetn,
	input wire bil_pkg::bil_src_t src,
	input wire bil_pkg::bil_bus_t bus,
	input wire logic [2:0]        cpu_int_n,
	input wire bil_pkg::bil_ack_t ack,
	input wire logic [1:0]        timer_pending
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Six low samples cover the synchroniser and the output register.
	a_uart_pass: assert property (!src.uart_irq_out_n [*6] |-> !cpu_int_n[2])
		else $error("uart interrupt not passed");
	a_edge_a: assert property ($rose(src.timer_a_output) |-> ##[4:6] !cpu_int_n[0])
		else $error("timer a edge lost");
	a_edge_b: assert property ($rose(src.timer_b_output) |-> ##[4:6] !cpu_int_n[1])
		else $error("timer b edge lost");
	a_hold_a: assert property (!cpu_int_n[0] && !ack.ack_a |=> !cpu_int_n[0])
		else $error("timer a dropped early");
	a_hold_b: assert property (!cpu_int_n[1] && !ack.ack_b |=> !cpu_int_n[1])
		else $error("timer b dropped early");
	a_ack_decode: assert property ($fell(bus.rd_n) && (bus.addr & `BIL_PHYS_MASK) == `BIL_ACK_A_ADDR |=> ack.ack_a)
		else $error("timer a read missed");
	a_ack_clear: assert property (ack.ack_a && !($past(src.timer_a_output, 5) && !$past(src.timer_a_output, 6))
		|=> cpu_int_n[0] && !timer_pending[0])
		else $error("timer a not cleared");
	a_ack_b_only: assert property (ack.ack_b |-> ($past(bus.addr) & `BIL_PHYS_MASK) == `BIL_ACK_B_ADDR)
		else $error("timer b ack without its read");
endmodule

bind bil_irq_latch bil_irq_latch_properties bil_irq_latch_properties_inst (.clk_sys(clk_sys), .resetn(resetn),
	.src(src), .bus(bus), .cpu_int_n(cpu_int_n), .ack(ack), .timer_pending(timer_pending));
`default_nettype wire

// *** test/bil_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Processor side: one-cycle read strobes, a released bus shows the inverted address.
module bil_cpu_model (
	input  wire logic             clk_sys,
	output var bil_pkg::bil_bus_t bus
);
	// Idle bus at time zero.
	initial begin
		bus = '{addr: 32'h0, rd_n: 1'b1};
	end
	// Read data is never taken, since the timer chip drives the low byte.
	task automatic rd(input logic [31:0] a);
		@(posedge clk_sys) #1;
		bus.addr = a;
		bus.rd_n = 1'b0;
		@(posedge clk_sys) #1;
		bus.rd_n = 1'b1;
		bus.addr = ~a;
	endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bil_regs.svh"

module tb;
	logic              clk_sys;
	logic              resetn;
	bil_pkg::bil_src_t src;
	bil_pkg::bil_bus_t bus;
	logic [2:0]        cpu_int_n;
	bil_pkg::bil_ack_t ack;
	logic [1:0]        timer_pending;
	int                err_count = 0;
	int                total_checks = 0;
	int                cyc = 0;
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("MISMATCH %0t got %h exp %h", $time, g, e); \
	end \
end
	// Free-running bus clock.
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	bil_irq_latch bil_irq_latch_inst (.clk_sys(clk_sys), .resetn(resetn), .src(src), .bus(bus),
		.cpu_int_n(cpu_int_n), .ack(ack), .timer_pending(timer_pending));
	bil_cpu_model bil_cpu_model_inst (.clk_sys(clk_sys), .bus(bus));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// The whole run needs about 150 cycles, so this ceiling only trips on a hang.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic set_tmr(input int ch, input logic v);
		if (ch == 1)
			src.timer_b_output = v;
		else
			src.timer_a_output = v;
	endtask
	// Capture, hold across a pin drop and a wrong read, alias clear, then a held level.
	task automatic t_timer(input int ch);
		logic [2:0] hit;
		hit = ~(3'h1 << ch);
		set_tmr(ch, 1'b1);
		wait_cyc(7);
		`CHK(cpu_int_n, hit)
		`CHK(timer_pending, 2'h1 << ch)
		set_tmr(ch, 1'b0);
		bil_cpu_model_inst.rd(ch == 1 ? `BIL_ACK_A_ADDR : `BIL_ACK_B_ADDR);
		wait_cyc(6);
		`CHK(cpu_int_n, hit)
		set_tmr(ch, 1'b1);
		wait_cyc(8);
		bil_cpu_model_inst.rd((ch == 1 ? `BIL_ACK_B_ADDR : `BIL_ACK_A_ADDR) | 32'ha000_0000);
		wait_cyc(8);
		`CHK(cpu_int_n, 3'h7)
		`CHK(timer_pending, 2'h0)
		set_tmr(ch, 1'b0);
		wait_cyc(6);
		$display("timer %0d test done", ch);
	endtask
	// The UART level passes through and survives both acknowledge reads.
	task automatic t_uart();
		src.uart_irq_out_n = 1'b0;
		wait_cyc(8);
		`CHK(cpu_int_n, 3'h3)
		bil_cpu_model_inst.rd(`BIL_ACK_A_ADDR);
		bil_cpu_model_inst.rd(`BIL_ACK_B_ADDR);
		wait_cyc(4);
		`CHK(cpu_int_n, 3'h3)
		src.uart_irq_out_n = 1'b1;
		wait_cyc(8);
		`CHK(cpu_int_n, 3'h7)
		$display("uart test done");
	endtask
	// Reset values are checked while reset is still held.
	task automatic t_reset();
		wait_cyc(20);
		`CHK(cpu_int_n, 3'h7)
		`CHK(ack, 2'h0)
		`CHK(timer_pending, 2'h0)
		resetn = 1'b1;
		wait_cyc(8);
		$display("reset test done");
	endtask
	// A timer A edge lands in the cycle of its own clear read and must win; then a mid-run reset drops it.
	task automatic t_collide();
		set_tmr(0, 1'b1);
		wait_cyc(3);
		bil_cpu_model_inst.rd(`BIL_ACK_A_ADDR);
		wait_cyc(4);
		`CHK(cpu_int_n, 3'h6)
		`CHK(timer_pending, 2'h1)
		set_tmr(0, 1'b0);
		resetn = 1'b0;
		wait_cyc(2);
		`CHK(cpu_int_n, 3'h7)
		`CHK(timer_pending, 2'h0)
		resetn = 1'b1;
		wait_cyc(8);
		`CHK(cpu_int_n, 3'h7)
		`CHK(ack, 2'h0)
		$display("collide and reset test done");
	endtask
	initial begin
		resetn = 1'b0;
		src = '{uart_irq_out_n: 1'b1, timer_b_output: 1'b0, timer_a_output: 1'b0};
		t_reset();
		t_timer(0);
		t_timer(1);
		t_uart();
		t_collide();
		tally_and_finish();
	end
endmodule
`default_nettype wire
